// [logic/cypm_mapper.sv]
// Purpose: cyclic frame decoder, status/return frame builder and explicit register slave
// Assumes: cyclic frames and starter status come from logic on mclk
// Notes: one assignment per cyclic frame; explicit write-value write also assigns
`timescale 1ns/100ps

module cypm_mapper
(
	input  wire logic                    mclk,             // 250 MHz clock
	input  wire logic                    reset_n,          // async active-low reset
	input  wire logic                    ce,               // clock enable
	// avalon-mm slave
	input  wire logic [9:0]              avs_address,      // byte address
	input  wire logic                    avs_read,         // read request
	input  wire logic                    avs_write,        // write request
	input  wire logic [31:0]             avs_writedata,    // write data
	input  wire logic [3:0]              avs_byteenable,   // byte lanes
	output logic      [31:0]             avs_readdata,     // read data
	output logic                         avs_waitrequest,  // stall
	output logic                         irq,              // level interrupt
	// cyclic exchange
	input  wire logic                    ot_valid,         // output frame strobe
	input  wire cypm_pkg::cypm_ot_frame_t ot_frame,        // eight-word output frame
	output logic                         to_valid,         // return frame strobe
	output cypm_pkg::cypm_to_frame_t     to_frame,         // five-word return frame
	// starter side
	input  wire cypm_pkg::cypm_starter_t starter,          // starter flags and trip code
	output logic                         start_stop,       // run command
	output logic                         ramp_freeze,      // hold ramp
	output logic                         fault_reset,      // clear trip
	output logic                         external_trip,    // force trip
	output logic                         network_control   // network owns control
);

	logic                          rst_meta;
	logic                          rst_n;
	cypm_pkg::cypm_ctrl_t          control;
	logic [cypm_pkg::PNUM_W-1:0]   wr_select;
	logic [31:0]                   wr_value;
	logic [3:0][cypm_pkg::PNUM_W-1:0] rd_select;
	logic                          wr_pending;
	logic                          frame_d;
	logic [cypm_pkg::IRQ_W-1:0]    irq_status;
	logic [cypm_pkg::IRQ_W-1:0]    irq_mask;
	logic                          fault_d;
	logic [3:0][31:0]              sel_value;

	// reset release through two flops
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// bus decode
	wire        bus_req     = (avs_read || avs_write) && avs_waitrequest;
	wire        bus_commit  = (avs_read || avs_write) && !avs_waitrequest;
	wire [7:0]  bus_idx     = avs_address[9:2];
	wire        wr_commit   = ce && bus_commit && avs_write;
	wire [31:0] be_mask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire        hit_ctrl    = wr_commit && (bus_idx == cypm_pkg::IDX_CONTROL);
	wire        hit_wsel    = wr_commit && (bus_idx == cypm_pkg::IDX_WR_SELECT);
	wire        hit_wval    = wr_commit && (bus_idx == cypm_pkg::IDX_WR_VALUE);
	wire        hit_imask   = wr_commit && (bus_idx == cypm_pkg::IDX_IRQ_MASK);
	wire        hit_istat   = wr_commit && (bus_idx == cypm_pkg::IDX_IRQ_STAT);
	wire [7:0]  rsel_off    = bus_idx - cypm_pkg::IDX_RD_SEL0;
	wire [7:0]  rval_off    = bus_idx - cypm_pkg::IDX_RD_VAL0;
	wire        is_rsel     = (rsel_off < 8'h04);
	wire        is_rval     = (rval_off < 8'h04);
	wire        frame_take  = ce && ot_valid;

	// merge a bus write into a 16-bit or 32-bit register under byte enables
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	// a function result cannot be part-selected, so the merges land on named wires first
	wire [31:0] merged_ctrl  = merge({16'h0000, control}, avs_writedata, be_mask);
	wire [31:0] merged_wsel  = merge({16'h0000, wr_select}, avs_writedata, be_mask);

	// explicit writes to read-only status and selected values fall through to nothing
	wire [15:0] next_control = frame_take ? ot_frame.ctrl : merged_ctrl[15:0];
	wire [15:0] next_wsel    = frame_take ? ot_frame.wr_select : merged_wsel[15:0];
	wire [31:0] next_wval    = frame_take ? ot_frame.wr_value :
		merge(wr_value, avs_writedata, be_mask);

	// a cyclic frame overrides an explicit write landing on the same edge
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			control   <= cypm_pkg::RST_CONTROL;
			wr_select <= cypm_pkg::RST_SELECT;
			wr_value  <= cypm_pkg::RST_VALUE;
		end
		else if (ce)
		begin
			if (frame_take || hit_ctrl)
				control <= next_control;
			if (frame_take || hit_wsel)
				wr_select <= next_wsel;
			if (frame_take || hit_wval)
				wr_value <= next_wval;
		end
	end

	for (genvar g = 0; g < 4; g++)
	begin : g_rsel
		wire        hit        = wr_commit && is_rsel && (rsel_off[1:0] == 2'(g));
		wire [31:0] merged_sel = merge({16'h0000, rd_select[g]}, avs_writedata, be_mask);
		always_ff @(posedge mclk or negedge rst_n)
		begin
			if (!rst_n)
				rd_select[g] <= cypm_pkg::RST_SELECT;
			else if (frame_take)
				rd_select[g] <= ot_frame.rd_select[g];
			else if (hit)
				rd_select[g] <= merged_sel[15:0];
		end
	end

	// assignment is one cycle after the select and value settle
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pending <= 1'b0;
			frame_d    <= 1'b0;
			to_valid   <= 1'b0;
		end
		else if (ce)
		begin
			wr_pending <= frame_take || hit_wval;
			frame_d    <= frame_take;
			to_valid   <= frame_d;
		end
	end

	cypm_param_store u_store
	(
		.mclk   (mclk),
		.rst_n  (rst_n),
		.ce     (ce),
		.wr_en  (wr_pending),
		.wr_num (wr_select),
		.wr_val (wr_value),
		.rd_num (rd_select),
		.rd_val (sel_value)
	);

	// control actions: only while network control is set
	wire        net_on       = control.net_ctrl;
	wire [3:0]  act_bits     = net_on ? {control.ext_trip, control.fault_reset,
		control.ramp_freeze, control.start_stop} : 4'h0;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_stop      <= 1'b0;
			ramp_freeze     <= 1'b0;
			fault_reset     <= 1'b0;
			external_trip   <= 1'b0;
			network_control <= 1'b0;
		end
		else if (ce)
		begin
			start_stop      <= act_bits[0];
			ramp_freeze     <= act_bits[1];
			fault_reset     <= act_bits[2];
			external_trip   <= act_bits[3];
			network_control <= net_on;
		end
	end

	// status word; reserved bits stay zero and the trip code shows only on fault
	wire [15:0] trip_field  = starter.fault ? starter.trip_code : 16'h0000;
	wire [6:0]  stat_flags  = {net_on, starter.stopping, starter.energy_recovery_active,
		starter.current_limiting, starter.start_completed, starter.running,
		starter.fault};
	wire [31:0] status_word = {trip_field, 9'h000, stat_flags};

	// return frame refreshed every cycle so it never lags the selectors by more than one
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			to_frame <= '0;
		else if (ce)
		begin
			to_frame.status <= status_word;
			to_frame.value  <= sel_value;
		end
	end

	// interrupt events: frame received, parameter assigned, fault rising
	wire [cypm_pkg::IRQ_W-1:0] irq_set = {starter.fault && !fault_d,
		wr_pending && cypm_pkg::cypm_in_range(wr_select), frame_take};
	wire [cypm_pkg::IRQ_W-1:0] irq_clr = hit_istat ?
		(avs_writedata[cypm_pkg::IRQ_W-1:0] & {cypm_pkg::IRQ_W{avs_byteenable[0]}}) : '0;
	wire [cypm_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_status <= '0;
			irq_mask   <= cypm_pkg::RST_MASK;
			fault_d    <= 1'b0;
			irq        <= 1'b0;
		end
		else if (ce)
		begin
			irq_status <= next_irq_status;
			fault_d    <= starter.fault;
			if (hit_imask && avs_byteenable[0])
				irq_mask <= avs_writedata[cypm_pkg::IRQ_W-1:0];
			irq        <= |(next_irq_status & irq_mask);
		end
	end

	// read mux; unmapped addresses read zero
	wire [31:0] rd_mux =
		(bus_idx == cypm_pkg::IDX_CONTROL)   ? {16'h0000, control} :
		(bus_idx == cypm_pkg::IDX_STATUS)    ? status_word :
		(bus_idx == cypm_pkg::IDX_WR_SELECT) ? {16'h0000, wr_select} :
		(bus_idx == cypm_pkg::IDX_WR_VALUE)  ? wr_value :
		is_rsel                              ? {16'h0000, rd_select[rsel_off[1:0]]} :
		is_rval                              ? sel_value[rval_off[1:0]] :
		(bus_idx == cypm_pkg::IDX_IRQ_STAT)  ? {29'h0, irq_status} :
		(bus_idx == cypm_pkg::IDX_IRQ_MASK)  ? {29'h0, irq_mask} : 32'h0000_0000;

	// one wait cycle per access keeps the read path registered
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end
		else if (ce)
		begin
			avs_waitrequest <= !bus_req;
			if (bus_req && avs_read)
				avs_readdata <= rd_mux;
		end
	end

endmodule // cypm_mapper

// [logic/cypm_pkg.sv]
// Purpose: shared constants, types and helpers of the cyclic io parameter mapper
// Assumes: one clock domain; register offsets are explicit-message instance indices
// Notes: byte address of a register is four times its index
//
// Overview of operation
// - Control bits zero to three act on the starter only while the network-control bit is set.
// - Control word bit 0 start/stop, 1 ramp freeze, 2 fault reset, 3 external trip, 4 network control, 5-15 reserved.
// - The second output word names the parameter to write, and a zero number writes nothing.
// - The write value is a 32-bit container, and a narrower parameter keeps only its low-order part.
// - The last four output words select returned parameters, and a zero selector returns zero.
// - The device returns five 32-bit words: status followed by four selected parameter values.
// - Status bit 0 fault, 1 running, 2 start completed, 3 current limiting, 4 energy recovery active, 5 stopping, 6 network control active, 7-15 reserved, 16-31 trip code.
// - While the fault flag is set the trip code fills the upper half of the status word.
// - Returned values narrower than 32 bits sit right-aligned, wider ones are cut to their low 32 bits.
// - The values picked by read selectors one to four fill returned words two to five in order.
// - Every datum is reachable alone by explicit access, status and selected values read-only.

package cypm_pkg;

	// explicit-message instance indices (byte address = index * 4)
	localparam logic [7:0] IDX_CONTROL   = 8'h02;
	localparam logic [7:0] IDX_STATUS    = 8'h03;
	localparam logic [7:0] IDX_WR_SELECT = 8'h64;
	localparam logic [7:0] IDX_WR_VALUE  = 8'h65;
	localparam logic [7:0] IDX_RD_SEL0   = 8'h66;
	localparam logic [7:0] IDX_RD_VAL0   = 8'h6a;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h70;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h71;
	localparam int         ADDR_W        = 10;

	// field positions
	localparam int CTRL_ACT_W   = 4;
	localparam int STAT_FLAG_W  = 7;
	localparam int TRIP_LSB     = 16;
	localparam int IRQ_W        = 3;
	localparam int IRQ_FRAME    = 0;
	localparam int IRQ_PWRITE   = 1;
	localparam int IRQ_FAULT    = 2;

	// parameter store layout
	localparam int              PNUM_W      = 16;
	localparam int              PARAM_COUNT = 64;
	localparam logic [PNUM_W-1:0] PNUM_WIDE_FIRST = 16'h0020;
	localparam logic [31:0]     NARROW_MASK = 32'h0000_ffff;

	// reset values
	localparam logic [15:0] RST_CONTROL  = 16'h0000;
	localparam logic [15:0] RST_SELECT   = 16'h0000;
	localparam logic [31:0] RST_VALUE    = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] RST_MASK = 3'h0;

	typedef struct packed {
		logic [10:0] reserved;
		logic        net_ctrl;
		logic        ext_trip;
		logic        fault_reset;
		logic        ramp_freeze;
		logic        start_stop;
	} cypm_ctrl_t;

	typedef struct packed {
		cypm_ctrl_t                   ctrl;
		logic [PNUM_W-1:0]            wr_select;
		logic [31:0]                  wr_value;
		logic [3:0][PNUM_W-1:0]       rd_select;
	} cypm_ot_frame_t;

	typedef struct packed {
		logic [31:0]      status;
		logic [3:0][31:0] value;
	} cypm_to_frame_t;

	typedef struct packed {
		logic        fault;
		logic        running;
		logic        start_completed;
		logic        current_limiting;
		logic        energy_recovery_active;
		logic        stopping;
		logic [15:0] trip_code;
	} cypm_starter_t;

	// parameters below the wide boundary are 16-bit and keep the low half only
	function automatic logic [31:0] cypm_fit(input logic [PNUM_W-1:0] num,
		input logic [31:0] val);
		cypm_fit = (num < PNUM_WIDE_FIRST) ? (val & NARROW_MASK) : val;
	endfunction

	function automatic logic cypm_in_range(input logic [PNUM_W-1:0] num);
		cypm_in_range = (num != '0) && (num < PNUM_W'(PARAM_COUNT));
	endfunction

endpackage

// [logic/cypm_param_store.sv]
// Purpose: numbered parameter storage with one write port and four read ports
// Assumes: write and reads on mclk; reads are combinational
// Notes: parameter zero and numbers past the store never hold data
`timescale 1ns/100ps

module cypm_param_store
(
	input  wire logic                              mclk,      // clock
	input  wire logic                              rst_n,     // synchronised reset
	input  wire logic                              ce,        // clock enable
	input  wire logic                              wr_en,     // assign strobe
	input  wire logic [cypm_pkg::PNUM_W-1:0]       wr_num,    // parameter to assign
	input  wire logic [31:0]                       wr_val,    // 32-bit container
	input  wire logic [3:0][cypm_pkg::PNUM_W-1:0]  rd_num,    // read selectors
	output logic      [3:0][31:0]                  rd_val     // selected values
);

	logic [31:0] mem [cypm_pkg::PARAM_COUNT];
	logic        do_write;

	assign do_write = ce && wr_en && cypm_pkg::cypm_in_range(wr_num);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < cypm_pkg::PARAM_COUNT; i++)
				mem[i] <= cypm_pkg::RST_VALUE;
		end
		else if (do_write)
			mem[wr_num[5:0]] <= cypm_pkg::cypm_fit(wr_num, wr_val);
	end

	// zero or unknown selector yields zero; narrow values are right-aligned already
	for (genvar g = 0; g < 4; g++)
	begin : g_rd
		assign rd_val[g] = cypm_pkg::cypm_in_range(rd_num[g]) ? mem[rd_num[g][5:0]] : 32'h0000_0000;
	end

endmodule // cypm_param_store

// [dv/cypm_asserts.sv]
// Purpose: port checks of the mapper
// Assumes: ce held high
// Notes: frame checks want three quiet cycles after a frame
`timescale 1ns/100ps

module cypm_asserts
(
	input wire logic                     mclk,            // clock
	input wire logic                     reset_n,         // reset
	input wire logic                     avs_read,        // read
	input wire logic                     avs_write,       // write
	input wire logic                     avs_waitrequest, // stall
	input wire logic                     ot_valid,        // frame strobe
	input wire cypm_pkg::cypm_ot_frame_t ot_frame,        // output frame
	input wire logic                     to_valid,        // return strobe
	input wire cypm_pkg::cypm_to_frame_t to_frame,        // return frame
	input wire cypm_pkg::cypm_starter_t  starter,         // starter flags
	input wire logic                     start_stop,      // run
	input wire logic                     ramp_freeze,     // hold
	input wire logic                     fault_reset,     // clear
	input wire logic                     external_trip,   // trip
	input wire logic                     network_control  // owner
);
	logic [1:0] up_cnt;
	wire        live = (up_cnt == 2'h3);

	// the design holds its own reset two edges past the pin
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			up_cnt <= 2'h0;
		else if (!live)
			up_cnt <= up_cnt + 2'h1;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!live);

	sequence s_frame_alone;
		ot_valid ##1 !ot_valid [*3];
	endsequence

	a_frame_answer: assert property (ot_valid |=> ##1 to_valid)
		else $error("no return frame");
	a_ctrl_follow: assert property (s_frame_alone |->
		network_control == $past(ot_frame.ctrl.net_ctrl, 3)
		&& start_stop == ($past(ot_frame.ctrl.start_stop, 3) & network_control))
		else $error("control outputs wrong");
	a_ctrl_gated: assert property (!network_control |->
		!(start_stop || ramp_freeze || fault_reset || external_trip))
		else $error("control acts without network control");
	a_stat_reserved: assert property (to_frame.status[15:7] == 9'h0)
		else $error("reserved status bits set");
	a_net_status: assert property (to_frame.status[6] == network_control)
		else $error("network control flag wrong");
	a_status_flags: assert property (to_frame.status[1] == $past(starter.running)
		&& to_frame.status[5] == $past(starter.stopping))
		else $error("status flags wrong");
	a_trip_gated: assert property (!to_frame.status[0] |-> to_frame.status[31:16] == 16'h0)
		else $error("trip code without fault");
	a_trip_code: assert property (to_frame.status[0] |->
		to_frame.status[31:16] == $past(starter.trip_code))
		else $error("trip code wrong");
	a_zero_select: assert property (s_frame_alone ##0
		$past(ot_frame.rd_select[0], 3) == 16'h0 |=> to_frame.value[0] == 32'h0)
		else $error("zero selector gave data");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest)
		else $error("bus access not answered");
endmodule // cypm_asserts

bind cypm_mapper cypm_asserts cypm_asserts_i (.*);

// [dv/cypm_plc_model.sv]
// Purpose: controller that originates the cyclic output frames
// Assumes: one frame per send pulse, eight 16-bit words
// Notes: between frames the lines toggle each cycle between the inverted and the true last frame
`timescale 1ns/100ps

module cypm_plc_model
(
	input  wire logic                 mclk,                    // clock
	input  wire logic                 send,                    // send a frame
	input  wire logic [7:0][15:0]     controller_output_array, // word 0 first
	output logic                      ot_valid,                // frame strobe
	output cypm_pkg::cypm_ot_frame_t  ot_frame                 // frame out
);
	wire [7:0][15:0] w = controller_output_array;
	// words 2 and 3 carry one 32-bit value, low half first
	wire cypm_pkg::cypm_ot_frame_t next_frame = {w[0], w[1], w[3], w[2],
		w[7], w[6], w[5], w[4]};

	initial
	begin
		ot_valid = 1'b0;
		ot_frame = '0;
	end

	// stale words must never pass for fresh ones
	always @(posedge mclk)
	begin
		ot_valid <= send;
		ot_frame <= send ? next_frame : ~ot_frame;
	end
endmodule // cypm_plc_model

// [dv/cyclic_io_param_mapper_tb_top.sv]
// Purpose: self-checking bench of the mapper
// Assumes: ce and byte enables held high
// Notes: frames come from the controller model
`timescale 1ns/100ps

module cyclic_io_param_mapper_tb_top;
	logic                     mclk = 1'b0, reset_n = 1'b0, ce = 1'b1;
	logic [9:0]               avs_address = 10'h0;
	logic                     avs_read = 1'b0, avs_write = 1'b0, send = 1'b0;
	logic [31:0]              avs_writedata = 32'h0, avs_readdata, rdat;
	logic [3:0]               avs_byteenable = 4'hf;
	logic                     avs_waitrequest, irq, ot_valid, to_valid;
	logic                     start_stop, ramp_freeze, fault_reset;
	logic                     external_trip, network_control;
	cypm_pkg::cypm_ot_frame_t ot_frame;
	cypm_pkg::cypm_to_frame_t to_frame;
	cypm_pkg::cypm_starter_t  starter = '0;
	logic [7:0][15:0]         words = '0;
	int                       miscompares = 0, n_tests = 0;

	always #2 mclk = ~mclk;

	cypm_mapper cypm_mapper_i (.*);
	cypm_plc_model cypm_plc_model_i (.mclk(mclk), .send(send),
		.controller_output_array(words), .ot_valid(ot_valid), .ot_frame(ot_frame));

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic limit(input int n);
		if (n >= 40)
		begin
			check(32'h0, 32'h1, "wait ran out");
			conclude();
		end
	endtask

	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 40);
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		limit(n);
	endtask

	// returns one cycle after the return strobe, when values are fresh
	task automatic frame(input logic [15:0] c, s, input logic [31:0] v, input logic [63:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		words <= {r, v, s, c};
		send <= 1'b1;
		@(posedge mclk);
		send <= 1'b0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (to_valid !== 1'b1 && n < 40);
		limit(n);
		@(negedge mclk);
	endtask

	task automatic t_control();
		for (int b = 0; b < 4; b++)
		begin
			frame(16'hffe0 | (16'h1 << b), 16'h0, 32'h0, 64'h0);
			check(32'({external_trip, fault_reset, ramp_freeze, start_stop}), 32'h0, "gated");
			frame(16'hfff0 | (16'h1 << b), 16'h0, 32'h0, 64'h0);
			check(32'({external_trip, fault_reset, ramp_freeze, start_stop}), 32'h1 << b, "ctrl");
			check(to_frame.status, 32'h40, "net status");
		end
		$display("control test done");
	endtask

	task automatic t_param();
		logic [3:0][31:0] exp;
		exp = {32'h5678, 32'h0, 32'hcafe_f00d, 32'h5678};
		frame(16'h0, 16'h5, 32'h1234_5678, 64'h0);
		check(to_frame.value[0], 32'h0, "zero select");
		frame(16'h0, 16'h28, 32'hcafe_f00d, 64'h0005_0000_0028_0005);
		for (int i = 0; i < 4; i++)
			check(to_frame.value[i], exp[i], "values");
		frame(16'h0, 16'h0, 32'hffff_ffff, 64'h0005_0000_0028_0005);
		for (int i = 0; i < 4; i++)
			check(to_frame.value[i], exp[i], "no assign");
		$display("parameter test done");
	endtask

	task automatic t_status();
		@(posedge mclk);
		starter <= 22'h36_00a5; // fault running - limit recovery - | trip
		repeat (3) @(negedge mclk);
		check(to_frame.status, 32'h00a5_001b, "trip");
		bus(1'b1, 10'h00c, 32'hffff_ffff);
		bus(1'b0, 10'h00c, 32'h0);
		check(rdat, 32'h00a5_001b, "status read");
		starter <= 22'h17_00a5;
		repeat (3) @(negedge mclk);
		check(to_frame.status, 32'h3a, "no fault");
		$display("status test done");
	endtask

	task automatic t_explicit();
		bus(1'b1, 10'h198, 32'h28);
		bus(1'b1, 10'h1a4, 32'h5);
		bus(1'b1, 10'h1a8, 32'h0);
		bus(1'b0, 10'h1a8, 32'h0);
		check(rdat, 32'hcafe_f00d, "first value");
		bus(1'b0, 10'h1b4, 32'h0);
		check(rdat, 32'h5678, "fourth value");
		bus(1'b1, 10'h190, 32'h9);
		bus(1'b1, 10'h194, 32'hdead_beef);
		bus(1'b1, 10'h198, 32'h9);
		bus(1'b0, 10'h1a8, 32'h0);
		check(rdat, 32'hbeef, "explicit assign");
		bus(1'b0, 10'h3fc, 32'h0);
		check(rdat, 32'h0, "unmapped");
		bus(1'b1, 10'h008, 32'h11);
		repeat (2) @(negedge mclk);
		check(32'({network_control, start_stop}), 32'h3, "explicit ctrl");
		$display("explicit test done");
	endtask

	task automatic t_irq();
		bus(1'b1, 10'h1c0, 32'h7);
		bus(1'b1, 10'h1c4, 32'h1);
		frame(16'h0, 16'h0, 32'h0, 64'h0);
		check(32'(irq), 32'h1, "irq set");
		bus(1'b0, 10'h1c0, 32'h0);
		check(rdat & 32'h1, 32'h1, "irq status");
		bus(1'b1, 10'h1c0, 32'h1);
		repeat (2) @(negedge mclk);
		check(32'(irq), 32'h0, "irq clear");
		bus(1'b1, 10'h1c4, 32'h0);
		frame(16'h0, 16'h0, 32'h0, 64'h0);
		check(32'(irq), 32'h0, "irq masked");
		$display("interrupt test done");
	endtask

	initial
	begin
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_control();
		t_param();
		t_status();
		t_explicit();
		t_irq();
		conclude();
	end
endmodule // cyclic_io_param_mapper_tb_top
